// >>> logic/nvram_access_protect_pkg.sv
package nvram_access_protect_pkg;

  // Register addresses on the SFR bus
  localparam logic [7:0] FIRST_CONFIG_ADDR = 8'hDC;
  localparam logic [7:0] PROTECT_ADDR = 8'hDD;
  localparam logic [7:0] DEV_MEM_CONFIG_ADDR = 8'hF6;

  // first_config_register fields
  localparam int IDLE_BIT = 7;
  localparam int CLKDIV_LSB = 4;
  localparam int OPSEL_LSB = 1;
  localparam int RUN_BIT = 0;

  // protection_register fields
  localparam int PROT_WP_BIT = 7;
  localparam int PROT_BP_LSB = 2;
  localparam int PROT_WEL_BIT = 1;
  localparam logic [7:0] PROT_WRITABLE_MASK = 8'h8C;

  // device_memory_config fields
  localparam int EXT_BUS_EN_BIT = 7;
  localparam int NV_MEM_EN_BIT = 6;

  // Values after reset
  localparam logic [7:0] PROTECT_RESET = 8'h00;
  localparam logic [7:0] DEV_MEM_CONFIG_RESET = 8'h00;
  localparam logic [1:0] CLKDIV_RESET = 2'h0;
  localparam logic [1:0] OPSEL_RESET = 2'h0;

  // External data window and protected regions
  localparam logic [15:0] NV_BASE = 16'h8000;
  localparam logic [15:0] NV_LAST = 16'h9FFF;
  localparam logic [15:0] BP_QUARTER_BASE = 16'h8800;
  localparam logic [15:0] BP_QUARTER_LAST = 16'h8FFF;
  localparam logic [15:0] BP_HALF_BASE = 16'h9000;
  localparam int NV_DEPTH = 8192;
  localparam int NV_AW = 13;

  // Operation select codes
  typedef enum logic [1:0] {
    OP_SET_WEL = 2'h0,
    OP_CLR_WEL = 2'h1,
    OP_REFRESH = 2'h2,
    OP_STORE = 2'h3
  } op_sel_t;

  // Block protect select codes
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_ALL = 2'h3;

  // Module clock divisors per divider code
  localparam logic [3:0] DIV_CODE0 = 4'h2;
  localparam logic [3:0] DIV_CODE1 = 4'h3;
  localparam logic [3:0] DIV_CODE2 = 4'h4;
  localparam logic [3:0] DIV_CODE3 = 4'h8;

  // Timing: typical access times at the nominal divide-by-two module clock
  localparam real CLK_PERIOD_NS = 4.0;
  localparam real NOMINAL_DIV = 2.0;
  localparam real READ_TIME_US = 1.9;
  localparam real WRITE_TIME_US = 2.6;
  localparam int READ_MOD_CYCLES = $rtoi(READ_TIME_US * 1000.0 / (CLK_PERIOD_NS * NOMINAL_DIV));
  localparam int WRITE_MOD_CYCLES = $rtoi(WRITE_TIME_US * 1000.0 / (CLK_PERIOD_NS * NOMINAL_DIV));
  localparam int CMD_MOD_CYCLES = 8;
  localparam int MOD_CNT_W = 9;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD = 4'b0010,
    ST_READ = 4'b0100,
    ST_WRITE = 4'b1000
  } nv_state_t;

endpackage

// >>> logic/nvram_access_protect_ctrl.sv
// Operation
// - Code 00 sets latch, 01 clears it
// - Code 10 refreshes register, 11 stores it
// - Run bit starts the selected operation
// - Select and run together or separately
// - Commands take module cycles, core continues
// - Bit 1 mirrors write latch, read only
// - Protect enable bit gates block protection
// - Protect field selects the protected region
// - Write register, then 07h stores it
// - Write 05h, then read refreshed register
// - Memory mapped 8000h to 9FFFh, xdata
// - Both enable bits needed for access
// - Core stalled until each access completes
// - Interrupts held pending during an access
// - Read 1.9us, write 2.6us at half clock
// - Idle bit reads 1 when idle
// - Divider code selects clock by 2,3,4,8
`timescale 1ns/1ns
module nvram_access_protect_ctrl
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // SFR bus from the core
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // External data accesses from the core
  input wire logic [15:0] xdata_addr_i,
  input wire logic xdata_rd_i,
  input wire logic xdata_wr_i,
  input wire logic [7:0] xdata_wdata_i,
  output logic [7:0] xdata_rdata_o,
  output logic xdata_hit_o,
  // Core control
  output logic core_stall_o,
  output logic irq_hold_o
);

  nvram_access_protect_pkg::nv_state_t state;
  logic [7:0] dev_mem_config;
  logic [7:0] protection_register;
  logic [7:0] prot_internal;
  logic write_enable_latch_flag;
  logic [1:0] module_clock_divider;
  logic [1:0] operation_select;
  logic operation_run;
  nvram_access_protect_pkg::op_sel_t op_active;
  logic [3:0] div_cnt;
  logic [3:0] divisor;
  logic mod_tick;
  logic [nvram_access_protect_pkg::MOD_CNT_W-1:0] mod_left;
  logic pend_valid;
  logic pend_write;
  logic [nvram_access_protect_pkg::NV_AW-1:0] pend_index;
  logic [7:0] pend_wdata;
  logic [7:0] nv_mem [0:nvram_access_protect_pkg::NV_DEPTH-1];
  logic mem_enabled;
  logic in_window;
  logic xreq;
  logic idle_status;
  logic access_busy;
  logic start_access;
  logic start_cmd;
  logic phase_done;
  logic write_blocked;
  logic [15:0] pend_addr_full;
  logic cfg_wr;
  logic prot_wr;
  logic [7:0] cfg_read_value;
  logic [7:0] prot_read_value;

  localparam logic [nvram_access_protect_pkg::MOD_CNT_W-1:0] READ_LOAD =
    nvram_access_protect_pkg::MOD_CNT_W'(nvram_access_protect_pkg::READ_MOD_CYCLES);
  localparam logic [nvram_access_protect_pkg::MOD_CNT_W-1:0] WRITE_LOAD =
    nvram_access_protect_pkg::MOD_CNT_W'(nvram_access_protect_pkg::WRITE_MOD_CYCLES);
  localparam logic [nvram_access_protect_pkg::MOD_CNT_W-1:0] CMD_LOAD =
    nvram_access_protect_pkg::MOD_CNT_W'(nvram_access_protect_pkg::CMD_MOD_CYCLES);

  assign cfg_wr = sfr_wr_i && (sfr_addr_i == nvram_access_protect_pkg::FIRST_CONFIG_ADDR);
  assign prot_wr = sfr_wr_i && (sfr_addr_i == nvram_access_protect_pkg::PROTECT_ADDR);

  // Module clock divider
  always_comb
  begin
    case (module_clock_divider)
      2'h0: divisor = nvram_access_protect_pkg::DIV_CODE0;
      2'h1: divisor = nvram_access_protect_pkg::DIV_CODE1;
      2'h2: divisor = nvram_access_protect_pkg::DIV_CODE2;
      default: divisor = nvram_access_protect_pkg::DIV_CODE3;
    endcase
  end

  // Compare with >= so a smaller divisor written mid-count cannot strand the counter
  assign mod_tick = (div_cnt >= (divisor - 4'h1));

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      div_cnt <= 4'h0;
    else if (mod_tick)
      div_cnt <= 4'h0;
    else
      div_cnt <= div_cnt + 4'h1;
  end

  // Address decode of the external data window
  assign mem_enabled = dev_mem_config[nvram_access_protect_pkg::EXT_BUS_EN_BIT]
    && dev_mem_config[nvram_access_protect_pkg::NV_MEM_EN_BIT];
  assign in_window = (xdata_addr_i >= nvram_access_protect_pkg::NV_BASE)
    && (xdata_addr_i <= nvram_access_protect_pkg::NV_LAST);
  assign xdata_hit_o = in_window && mem_enabled;
  assign xreq = (xdata_rd_i || xdata_wr_i) && xdata_hit_o && !pend_valid && !access_busy;

  assign access_busy = (state == nvram_access_protect_pkg::ST_READ) || (state == nvram_access_protect_pkg::ST_WRITE);
  assign start_access = (state == nvram_access_protect_pkg::ST_IDLE) && pend_valid;
  assign start_cmd = (state == nvram_access_protect_pkg::ST_IDLE) && !pend_valid && operation_run;
  assign phase_done = mod_tick && (mod_left == {{(nvram_access_protect_pkg::MOD_CNT_W-1){1'b0}}, 1'b1});

  // Stall from the request cycle until the access finishes; commands never stall
  assign core_stall_o = xreq || pend_valid || access_busy;
  assign irq_hold_o = core_stall_o;

  assign idle_status = (state == nvram_access_protect_pkg::ST_IDLE) && !pend_valid && !operation_run;

  // A request arriving during a command waits here until the command ends
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pend_valid <= 1'b0;
      pend_write <= 1'b0;
      pend_index <= '0;
      pend_wdata <= 8'h00;
    end
    else if (xreq)
    begin
      pend_valid <= 1'b1;
      pend_write <= xdata_wr_i;
      pend_index <= xdata_addr_i[nvram_access_protect_pkg::NV_AW-1:0];
      pend_wdata <= xdata_wdata_i;
    end
    else if (start_access)
      pend_valid <= 1'b0;
  end

  // Sequencer
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= nvram_access_protect_pkg::ST_IDLE;
      mod_left <= '0;
      op_active <= nvram_access_protect_pkg::OP_SET_WEL;
    end
    else
    begin
      case (state)
        nvram_access_protect_pkg::ST_IDLE:
        begin
          if (start_access)
          begin
            state <= pend_write ? nvram_access_protect_pkg::ST_WRITE : nvram_access_protect_pkg::ST_READ;
            mod_left <= pend_write ? WRITE_LOAD : READ_LOAD;
          end
          else if (start_cmd)
          begin
            state <= nvram_access_protect_pkg::ST_CMD;
            mod_left <= CMD_LOAD;
            op_active <= nvram_access_protect_pkg::op_sel_t'(operation_select);
          end
        end
        nvram_access_protect_pkg::ST_CMD,
        nvram_access_protect_pkg::ST_READ,
        nvram_access_protect_pkg::ST_WRITE:
        begin
          if (phase_done)
            state <= nvram_access_protect_pkg::ST_IDLE;
          else if (mod_tick)
            mod_left <= mod_left - {{(nvram_access_protect_pkg::MOD_CNT_W-1){1'b0}}, 1'b1};
        end
        default:
          state <= nvram_access_protect_pkg::ST_IDLE;
      endcase
    end
  end

  // first_config_register
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      module_clock_divider <= nvram_access_protect_pkg::CLKDIV_RESET;
      operation_select <= nvram_access_protect_pkg::OPSEL_RESET;
      operation_run <= 1'b0;
    end
    else
    begin
      if (cfg_wr)
      begin
        module_clock_divider <= sfr_wdata_i[nvram_access_protect_pkg::CLKDIV_LSB +: 2];
        operation_select <= sfr_wdata_i[nvram_access_protect_pkg::OPSEL_LSB +: 2];
      end
      // Setting the run bit wins over the self-clear; a written 0 cannot abort
      if (cfg_wr && sfr_wdata_i[nvram_access_protect_pkg::RUN_BIT])
        operation_run <= 1'b1;
      else if ((state == nvram_access_protect_pkg::ST_CMD) && phase_done)
        operation_run <= 1'b0;
    end
  end

  // Write latch and the array's own protection copy
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      write_enable_latch_flag <= 1'b0;
      prot_internal <= nvram_access_protect_pkg::PROTECT_RESET;
    end
    else if ((state == nvram_access_protect_pkg::ST_CMD) && phase_done)
    begin
      case (op_active)
        nvram_access_protect_pkg::OP_SET_WEL: write_enable_latch_flag <= 1'b1;
        nvram_access_protect_pkg::OP_CLR_WEL: write_enable_latch_flag <= 1'b0;
        nvram_access_protect_pkg::OP_STORE:
          prot_internal <= protection_register & nvram_access_protect_pkg::PROT_WRITABLE_MASK;
        default: ;
      endcase
    end
  end

  // protection_register as seen by software; a software write beats a refresh
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      protection_register <= nvram_access_protect_pkg::PROTECT_RESET;
    else if (prot_wr)
      protection_register <= sfr_wdata_i & nvram_access_protect_pkg::PROT_WRITABLE_MASK;
    else if ((state == nvram_access_protect_pkg::ST_CMD) && phase_done
             && (op_active == nvram_access_protect_pkg::OP_REFRESH))
      protection_register <= prot_internal;
  end

  // device_memory_config
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      dev_mem_config <= nvram_access_protect_pkg::DEV_MEM_CONFIG_RESET;
    else if (sfr_wr_i && (sfr_addr_i == nvram_access_protect_pkg::DEV_MEM_CONFIG_ADDR))
      dev_mem_config <= sfr_wdata_i;
  end

  // Block protection follows the copy held by the array, not the software view
  assign pend_addr_full = nvram_access_protect_pkg::NV_BASE | {3'b000, pend_index};
  always_comb
  begin
    write_blocked = 1'b0;
    if (prot_internal[nvram_access_protect_pkg::PROT_WP_BIT])
    begin
      case (prot_internal[nvram_access_protect_pkg::PROT_BP_LSB +: 2])
        nvram_access_protect_pkg::BP_QUARTER:
          write_blocked = (pend_addr_full >= nvram_access_protect_pkg::BP_QUARTER_BASE)
            && (pend_addr_full <= nvram_access_protect_pkg::BP_QUARTER_LAST);
        nvram_access_protect_pkg::BP_HALF:
          write_blocked = (pend_addr_full >= nvram_access_protect_pkg::BP_HALF_BASE);
        nvram_access_protect_pkg::BP_ALL:
          write_blocked = 1'b1;
        default:
          write_blocked = 1'b0;
      endcase
    end
  end

  // Array storage; contents survive reset
  always_ff @(posedge sys_clk_i)
  begin
    if ((state == nvram_access_protect_pkg::ST_WRITE) && phase_done && write_enable_latch_flag && !write_blocked)
      nv_mem[pend_index] <= pend_wdata;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      xdata_rdata_o <= 8'h00;
    else if ((state == nvram_access_protect_pkg::ST_READ) && phase_done)
      xdata_rdata_o <= nv_mem[pend_index];
  end

  // SFR read port
  assign cfg_read_value = {idle_status, 1'b0, module_clock_divider, 1'b0, operation_select, operation_run};
  always_comb
  begin
    prot_read_value = protection_register & nvram_access_protect_pkg::PROT_WRITABLE_MASK;
    prot_read_value[nvram_access_protect_pkg::PROT_WEL_BIT] = write_enable_latch_flag;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      sfr_rdata_o <= 8'h00;
    else if (sfr_rd_i)
    begin
      case (sfr_addr_i)
        nvram_access_protect_pkg::FIRST_CONFIG_ADDR: sfr_rdata_o <= cfg_read_value;
        nvram_access_protect_pkg::PROTECT_ADDR: sfr_rdata_o <= prot_read_value;
        nvram_access_protect_pkg::DEV_MEM_CONFIG_ADDR: sfr_rdata_o <= dev_mem_config;
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

// >>> verification/nvram_access_protect_assertions.sv
`timescale 1ns/1ns
module nvram_access_protect_checker
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // SFR bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  // External data and core control
  input wire logic [15:0] xdata_addr_i,
  input wire logic xdata_rd_i,
  input wire logic xdata_wr_i,
  input wire logic [7:0] xdata_wdata_i,
  input wire logic [7:0] xdata_rdata_o,
  input wire logic xdata_hit_o,
  input wire logic core_stall_o,
  input wire logic irq_hold_o
);
  localparam logic [7:0] CFG = nvram_access_protect_pkg::FIRST_CONFIG_ADDR;
  logic [1:0] div_code;
  logic rd_kind;
  logic [11:0] span;

  // Divider tracked so access spans are judged only at the nominal clock
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      div_code <= 2'h0;
    else if (sfr_wr_i && sfr_addr_i == CFG)
      div_code <= sfr_wdata_i[5:4];
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      span <= 12'h000;
    else if (!core_stall_o)
      span <= 12'h000;
    else
      span <= span + 12'h001;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rd_kind <= 1'b0;
    else if (span == 12'h000 && core_stall_o)
      rd_kind <= xdata_rd_i;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence run_write;
    sfr_wr_i && sfr_addr_i == CFG && sfr_wdata_i[0];
  endsequence
  sequence idle_poll;
    sfr_rd_i && sfr_addr_i == CFG;
  endsequence

  a_busy_after_run: assert property (run_write ##2 idle_poll |=> !sfr_rdata_o[7])
    else $error("idle bit high during command");
  a_cmd_no_stall: assert property (run_write |-> ##1 !core_stall_o [*8])
    else $error("core stalled by command");
  a_irq_follows_stall: assert property (irq_hold_o == core_stall_o)
    else $error("interrupt hold differs from stall");
  a_hit_in_window: assert property (xdata_hit_o |-> xdata_addr_i >= 16'h8000 && xdata_addr_i <= 16'h9FFF)
    else $error("hit outside window");
  a_stall_on_hit: assert property ((xdata_rd_i || xdata_wr_i) && xdata_hit_o && span == 12'h000
    |-> core_stall_o ##1 core_stall_o [*8])
    else $error("access did not stall core");
  a_miss_no_stall: assert property ((xdata_rd_i || xdata_wr_i) && !xdata_hit_o && span == 12'h000
    |-> !core_stall_o)
    else $error("missed access stalled core");
  a_read_span: assert property ($fell(core_stall_o) && rd_kind && div_code == 2'h0
    |-> span >= 12'h1D6 && span <= 12'h1F4)
    else $error("read duration out of range");
  a_write_span: assert property ($fell(core_stall_o) && !rd_kind && div_code == 2'h0
    |-> span >= 12'h286 && span <= 12'h2A4)
    else $error("write duration out of range");
  a_protect_reserved: assert property (sfr_rd_i && sfr_addr_i == 8'hDD
    |=> sfr_rdata_o[6:4] == 3'h0 && !sfr_rdata_o[0])
    else $error("protection reserved bits not zero");
endmodule

bind nvram_access_protect_ctrl nvram_access_protect_checker chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
  .sfr_rdata_o(sfr_rdata_o), .xdata_addr_i(xdata_addr_i), .xdata_rd_i(xdata_rd_i), .xdata_wr_i(xdata_wr_i),
  .xdata_wdata_i(xdata_wdata_i), .xdata_rdata_o(xdata_rdata_o), .xdata_hit_o(xdata_hit_o),
  .core_stall_o(core_stall_o), .irq_hold_o(irq_hold_o));

// >>> verification/core_model.sv
`timescale 1ns/1ns
module core_model
(
  // Clock and answers
  input wire logic sys_clk_i,
  input wire logic [7:0] sfr_rdata_i,
  input wire logic [7:0] xdata_rdata_i,
  input wire logic core_stall_i,
  // Requests
  output logic [7:0] sfr_addr_o,
  output logic sfr_wr_o,
  output logic sfr_rd_o,
  output logic [7:0] sfr_wdata_o,
  output logic [15:0] xdata_addr_o,
  output logic xdata_rd_o,
  output logic xdata_wr_o,
  output logic [7:0] xdata_wdata_o
);
  logic [7:0] last_rd;
  logic [7:0] last_x;
  // Counts polls and stalls that ran out, so a hang cannot pass silently
  int timeouts;

  initial
  begin
    {sfr_addr_o, sfr_wr_o, sfr_rd_o, sfr_wdata_o} = 18'h0;
    {xdata_addr_o, xdata_rd_o, xdata_wr_o, xdata_wdata_o} = 26'h0;
  end

  // Released lines show the inverse so stale values never pass
  task automatic sfr_cycle(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk_i);
    sfr_addr_o = addr;
    sfr_wdata_o = data;
    sfr_wr_o = wr;
    sfr_rd_o = !wr;
    @(negedge sys_clk_i);
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_addr_o = ~addr;
    sfr_wdata_o = ~data;
    last_rd = sfr_rdata_i;
  endtask

  task automatic wait_idle(output int reads, output logic first_idle);
    reads = 0;
    first_idle = 1'b1;
    do
    begin
      sfr_cycle(1'b0, nvram_access_protect_pkg::FIRST_CONFIG_ADDR, 8'h00);
      if (reads == 0)
        first_idle = last_rd[7];
      reads++;
    end
    while (!last_rd[7] && reads < 500);
    if (!last_rd[7])
      timeouts++;
  endtask

  // Address and data held until the stall ends
  task automatic xdata_cycle(input logic wr, input logic [15:0] addr, input logic [7:0] data, output logic seen);
    int n;
    @(negedge sys_clk_i);
    xdata_addr_o = addr;
    xdata_wdata_o = data;
    xdata_wr_o = wr;
    xdata_rd_o = !wr;
    @(negedge sys_clk_i);
    xdata_wr_o = 1'b0;
    xdata_rd_o = 1'b0;
    seen = core_stall_i;
    n = 0;
    while (core_stall_i && n < 3000)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    if (core_stall_i)
      timeouts++;
    xdata_addr_o = ~addr;
    xdata_wdata_o = ~data;
    last_x = xdata_rdata_i;
  endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ns
module tb;
  localparam logic [7:0] CFG = nvram_access_protect_pkg::FIRST_CONFIG_ADDR;
  logic sys_clk_i;
  logic rst_i;
  logic [7:0] sa, swd, srd, xwd, xrd;
  logic sw, sr, xr, xw, hit, stall, hold, seen, first;
  logic [15:0] xa;
  int failures, checks, cycles, n;

  nvram_access_protect_ctrl uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sfr_addr_i(sa), .sfr_wr_i(sw),
    .sfr_rd_i(sr), .sfr_wdata_i(swd), .sfr_rdata_o(srd), .xdata_addr_i(xa), .xdata_rd_i(xr), .xdata_wr_i(xw),
    .xdata_wdata_i(xwd), .xdata_rdata_o(xrd), .xdata_hit_o(hit), .core_stall_o(stall), .irq_hold_o(hold));
  core_model core (.sys_clk_i(sys_clk_i), .sfr_rdata_i(srd), .xdata_rdata_i(xrd), .core_stall_i(stall),
    .sfr_addr_o(sa), .sfr_wr_o(sw), .sfr_rd_o(sr), .sfr_wdata_o(swd), .xdata_addr_o(xa), .xdata_rd_o(xr),
    .xdata_wr_o(xw), .xdata_wdata_o(xwd));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      failures++;
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    core.sfr_cycle(1'b0, addr, 8'h00);
    check(core.last_rd, exp);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    core.sfr_cycle(1'b1, addr, data);
  endtask

  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // Ceiling well above the six array accesses of the run
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      close_out();
    end
  end

  initial
  begin
    rst_i = 1'b1;
    // Count rising edges so the time-zero clock step cannot shorten reset
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    rd(CFG, 8'h80);
    rd(8'hDD, 8'h00);
    rd(8'hF6, 8'h00);
    rd(8'h55, 8'h00);
    core.xdata_cycle(1'b0, 16'h8100, 8'h00, seen);
    check({7'h00, seen}, 8'h00);
    wr(8'hF6, 8'hC0);
    rd(8'hF6, 8'hC0);
    wr(CFG, 8'h01);
    core.wait_idle(n, first);
    check({7'h00, first}, 8'h00);
    core.xdata_cycle(1'b1, 16'h8100, 8'hA5, seen);
    check({7'h00, seen}, 8'h01);
    core.xdata_cycle(1'b0, 16'h8100, 8'h00, seen);
    check(core.last_x, 8'hA5);
    wr(8'hDD, 8'hFF);
    wr(CFG, 8'h06);
    wr(CFG, 8'h07);
    core.wait_idle(n, first);
    wr(CFG, 8'h05);
    core.wait_idle(n, first);
    rd(8'hDD, 8'h8E);
    core.xdata_cycle(1'b1, 16'h8100, 8'h5A, seen);
    core.xdata_cycle(1'b0, 16'h8100, 8'h00, seen);
    check(core.last_x, 8'hA5);
    // Divide by 3, by 4 and by 8: eight module ticks seen through the idle poll
    wr(CFG, 8'h11);
    core.wait_idle(n, first);
    check({7'h00, (n >= 11 && n <= 14)}, 8'h01);
    wr(CFG, 8'h21);
    core.wait_idle(n, first);
    check({7'h00, (n >= 15 && n <= 18)}, 8'h01);
    wr(CFG, 8'h33);
    core.wait_idle(n, first);
    check({7'h00, (n >= 30 && n <= 40)}, 8'h01);
    wr(CFG, 8'h35);
    core.wait_idle(n, first);
    rd(8'hDD, 8'h8C);
    wr(CFG, 8'h01);
    core.wait_idle(n, first);
    wr(8'hDD, 8'h0C);
    wr(CFG, 8'h07);
    core.wait_idle(n, first);
    core.xdata_cycle(1'b1, 16'h8100, 8'h3C, seen);
    core.xdata_cycle(1'b0, 16'h8100, 8'h00, seen);
    check(core.last_x, 8'h3C);
    check({7'h00, core.timeouts != 0}, 8'h00);
    close_out();
  end
endmodule
